// ===== ipl_regs.sv
// Priority level register bank with APB slave and request gating.
// Assumes src_irq comes from peripherals clocked by pclk.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
module ipl_regs
(
    input wire logic pclk, // 100 MHz clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [ipl_pkg::ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic [ipl_pkg::NUM_SRC-1:0] src_irq, // Source requests
    output logic [2*ipl_pkg::NUM_SRC-1:0] src_code, // Field codes
    output logic irq_req, // Request to core
    output logic [1:0] irq_level, // Winning level 0..2
    output logic [ipl_pkg::SRC_W-1:0] irq_src // Winning source
);
    logic [15:0] level_r [ipl_pkg::NUM_REG];
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic irq_req_r;
    logic [1:0] irq_level_r;
    logic [ipl_pkg::SRC_W-1:0] irq_src_r;
    logic [ipl_pkg::NUM_SRC-1:0] pend;
    logic [2*ipl_pkg::NUM_SRC-1:0] code;
    logic [5:0] idx;
    logic aligned;
    logic setup;
    logic wr_take;
    logic [31:0] rd_nxt;
    logic err_nxt;
    ipl_arb_if arb_if ();

    assign idx = paddr[ipl_pkg::ADDR_W-1:2];
    assign aligned = paddr[1:0] == 2'h0;
    assign setup = psel && !penable;
    // Zero wait state: access phase always completes
    assign pready = 1'b1;
    assign wr_take = psel && penable && pwrite && aligned;

    // Field extraction per source
    for (genvar i = 0; i < ipl_pkg::NUM_SRC; i++)
    begin : g_src
        assign code[2*i +: 2] =
            level_r[ipl_pkg::SRC_REG[i]][ipl_pkg::SRC_LSB[i] +: 2];
        assign pend[i] = src_irq[i] && (code[2*i +: 2] != ipl_pkg::CODE_OFF);
    end

    assign arb_if.pend = pend;
    assign arb_if.code = code;

    ipl_arbiter u_arb
    (
        .arb_if(arb_if.arb)
    );

    // Register writes, masked to defined fields
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int r = 0; r < ipl_pkg::NUM_REG; r++)
                level_r[r] <= ipl_pkg::RESET_VAL;
        end
        else if (wr_take)
        begin
            unique case (idx)
                ipl_pkg::IDX_SIX:
                    level_r[0] <= pwdata[15:0] & ipl_pkg::MASK_SIX;
                ipl_pkg::IDX_SEVEN:
                    level_r[1] <= pwdata[15:0] & ipl_pkg::MASK_SEVEN;
                ipl_pkg::IDX_EIGHT:
                    level_r[2] <= pwdata[15:0] & ipl_pkg::MASK_EIGHT;
                ipl_pkg::IDX_NINE:
                    level_r[3] <= pwdata[15:0] & ipl_pkg::MASK_NINE;
                default:
                    ;
            endcase
        end
    end

    // Read decode; status views are read only
    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        err_nxt = 1'b0;
        if (!aligned)
            err_nxt = 1'b1;
        else
        begin
            unique case (idx)
                ipl_pkg::IDX_SIX: rd_nxt = {16'h0000, level_r[0]};
                ipl_pkg::IDX_SEVEN: rd_nxt = {16'h0000, level_r[1]};
                ipl_pkg::IDX_EIGHT: rd_nxt = {16'h0000, level_r[2]};
                ipl_pkg::IDX_NINE: rd_nxt = {16'h0000, level_r[3]};
                ipl_pkg::IDX_PENDING: rd_nxt = {15'h0000, pend};
                ipl_pkg::IDX_WINNER:
                    rd_nxt = {24'h00_0000, arb_if.win_valid,
                              arb_if.win_code, arb_if.win_src};
                default: err_nxt = 1'b1;
            endcase
        end
    end

    // Read data latched in the setup cycle, shown in access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
        else if (setup)
        begin
            prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
            pslverr_r <= err_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pslverr = pslverr_r && psel && penable;

    // Core request registered one cycle after the source
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_req_r <= 1'b0;
            irq_level_r <= 2'h0;
            irq_src_r <= '0;
        end
        else
        begin
            // Only enabled winners reach the core
            irq_req_r <= arb_if.win_valid;
            irq_level_r <= arb_if.win_valid ?
                arb_if.win_code - ipl_pkg::CODE_LVL0 : 2'h0;
            irq_src_r <= arb_if.win_valid ? arb_if.win_src : '0;
        end
    end

    assign irq_req = irq_req_r;
    assign irq_level = irq_level_r;
    assign irq_src = irq_src_r;
    assign src_code = code;
endmodule

// ===== ipl_pkg.sv
// Constants for the interrupt priority level register bank.
// Assumes an APB slave on pclk; sources are synchronous to pclk.
// Overview of operation
// - Field code 00 disables, 01/10/11 give levels 0/1/2.
// - All priority fields reset to the disabled code.
// - Reserved bits read zero; writes to them are dropped.
// - Sixth register bits 3-2: quadrature index pulse level.
// - Sixth register bits 1-0: quadrature home or watchdog level.
// - Seventh register, offset 7: timer A ch0 at 15-14, 13-6 reserved.
// - Seventh register: timer C ch3, ch2, ch1 at 5-4, 3-2, 1-0.
// - Eighth register, offset 8: serial0 rx full 15-14, rx error 13-12.
// - Eighth register: serial0 tx idle 9-8, tx empty 7-6.
// - Eighth register: timer A ch3, ch2, ch1 at 5-4, 3-2, 1-0.
// - Ninth register, offset 9: PWM fault 15-14, PWM reload 11-10.
// - Ninth register: ADC zero crossing or limit 7-6, 5-4 reserved.
// - Ninth register: ADC conversion done 3-2, bits 1-0 reserved.
package ipl_pkg;
    localparam int NUM_SRC = 17;
    localparam int NUM_REG = 4;
    localparam int SRC_W = 5;
    localparam int ADDR_W = 8;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_SIX = 6'h06;
    localparam logic [5:0] IDX_SEVEN = 6'h07;
    localparam logic [5:0] IDX_EIGHT = 6'h08;
    localparam logic [5:0] IDX_NINE = 6'h09;
    localparam logic [5:0] IDX_PENDING = 6'h10;
    localparam logic [5:0] IDX_WINNER = 6'h11;

    // Writable bits per register, others reserved
    localparam logic [15:0] MASK_SIX = 16'h000f;
    localparam logic [15:0] MASK_SEVEN = 16'hc03f;
    localparam logic [15:0] MASK_EIGHT = 16'hf3ff;
    localparam logic [15:0] MASK_NINE = 16'hcccc;
    localparam logic [15:0] RESET_VAL = 16'h0000;

    localparam logic [1:0] CODE_OFF = 2'h0;
    localparam logic [1:0] CODE_LVL0 = 2'h1;
    localparam logic [1:0] CODE_LVL1 = 2'h2;
    localparam logic [1:0] CODE_LVL2 = 2'h3;

    // Winner status field positions
    localparam int WIN_VALID_BIT = 7;
    localparam int WIN_CODE_LSB = 5;

    // Per source: register slot (0 = sixth .. 3 = ninth) and field lsb
    localparam int SRC_REG [NUM_SRC] = '{0, 0, 1, 1, 1, 1, 2, 2, 2, 2,
                                         2, 2, 2, 3, 3, 3, 3};
    localparam int SRC_LSB [NUM_SRC] = '{2, 0, 14, 4, 2, 0, 14, 12, 8, 6,
                                         4, 2, 0, 14, 10, 6, 2};
endpackage

// ===== ipl_arb_if.sv
// Carrier between the register bank and the level arbiter.
// Assumes both ends run on pclk.
`timescale 1ns/100ps
interface ipl_arb_if;
    logic [ipl_pkg::NUM_SRC-1:0] pend;
    logic [2*ipl_pkg::NUM_SRC-1:0] code;
    logic win_valid;
    logic [ipl_pkg::SRC_W-1:0] win_src;
    logic [1:0] win_code;
    modport bank (output pend, output code, input win_valid,
                  input win_src, input win_code);
    modport arb (input pend, input code, output win_valid,
                 output win_src, output win_code);
endinterface

// ===== ipl_arbiter.sv
// Combinational level arbiter over the gated pending sources.
// Assumes pend is already masked by the enable state of each field.
`timescale 1ns/100ps
module ipl_arbiter
(
    ipl_arb_if.arb arb_if // Pending, codes in; winner out
);
    always_comb
    begin
        arb_if.win_valid = 1'b0;
        arb_if.win_src = '0;
        arb_if.win_code = ipl_pkg::CODE_OFF;
        // Downward scan: ties go to the lowest source number
        for (int i = ipl_pkg::NUM_SRC - 1; i >= 0; i--)
        begin
            if (arb_if.pend[i] && arb_if.code[2*i +: 2] >= arb_if.win_code)
            begin
                arb_if.win_valid = 1'b1;
                arb_if.win_src = ipl_pkg::SRC_W'(i);
                arb_if.win_code = arb_if.code[2*i +: 2];
            end
        end
    end
endmodule

// ===== ipl_src_model.sv
// Source model: each request line follows its command.
// Assumes commands change just after a pclk edge.
`timescale 1ns/100ps
module ipl_src_model
(
    input wire logic pclk, // Clock
    input wire logic [16:0] cmd, // Lines to raise
    output logic [16:0] src_irq // Request levels
);
    always_ff @(posedge pclk)
        src_irq <= cmd;
endmodule

// ===== ipl_regs_monitor.sv
// Assertions on the priority level bank's ports.
// Assumes a bind to ipl_regs; single pclk domain.
`timescale 1ns/100ps
module ipl_regs_monitor
(
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset
    input wire logic psel, // Select
    input wire logic penable, // Access
    input wire logic pwrite, // Write
    input wire logic [7:0] paddr, // Address
    input wire logic [31:0] pwdata, // Data
    input wire logic [16:0] src_irq, // Sources
    input wire logic [33:0] src_code, // Codes
    input wire logic irq_req, // Request
    input wire logic [1:0] irq_level, // Level
    input wire logic [4:0] irq_src // Winner
);
    logic [1:0] top_c;
    always_comb
    begin
        top_c = 2'h0;
        for (int i = 0; i < 17; i++)
            if (src_irq[i] && src_code[2*i+:2] > top_c)
                top_c = src_code[2*i+:2];
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_wr(a); psel && penable && pwrite && paddr == a; endsequence
    property p_gate; top_c == 2'h0 |=> !irq_req; endproperty
    a_gate: assert property (p_gate) else $error("stray request");
    property p_lvl; top_c != 2'h0 |=>
        irq_req && irq_level == $past(top_c) - 2'h1; endproperty
    a_lvl: assert property (p_lvl) else $error("wrong level");
    property p_max; irq_level != 2'h3; endproperty
    a_max: assert property (p_max) else $error("level above 2");
    property p_idle; !irq_req |-> irq_level == 2'h0 && irq_src == 5'h0;
    endproperty
    a_idle: assert property (p_idle) else $error("idle not zero");
    property p_rst; $rose(presetn) |-> src_code == 34'h0; endproperty
    a_rst: assert property (p_rst) else $error("field not off");
    property p_hold; !(psel && penable && pwrite) |=> $stable(src_code);
    endproperty
    a_hold: assert property (p_hold) else $error("code moved");
    property p_wr6; s_wr(8'h18) |=>
        src_code[3:0] == {$past(pwdata[1:0]), $past(pwdata[3:2])}; endproperty
    a_wr6: assert property (p_wr6) else $error("quad fields");
    property p_wr7; s_wr(8'h1c) |=> src_code[5:4] == $past(pwdata[15:14]);
    endproperty
    a_wr7: assert property (p_wr7) else $error("timer A ch0 field");
endmodule

// ===== ipl_regs_tb.sv
// Self-checking bench: APB driver and scoreboard queue.
// Assumes the package, source model and monitor come first.
`timescale 1ns/100ps
module ipl_regs_tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, irq_req;
    logic [1:0] irq_level, c;
    logic [4:0] irq_src;
    logic [7:0] paddr = 8'h0, exp_irq = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, seed = 32'hf918;
    logic [16:0] cmd = 17'h0, src_irq, pend;
    logic [33:0] src_code;
    logic [15:0] sh [4] = '{4{16'h0}};
    logic [15:0] mk [4] = '{ipl_pkg::MASK_SIX, ipl_pkg::MASK_SEVEN,
        ipl_pkg::MASK_EIGHT, ipl_pkg::MASK_NINE};
    logic [40:0] q [$];
    wire [40:0] seen = {pslverr, prdata, irq_req, irq_level, irq_src};
    int miscompares = 0, num_checks = 0, r;
    always #5 pclk = ~pclk;
    ipl_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .src_irq, .src_code,
        .irq_req, .irq_level, .irq_src);
    ipl_src_model src (.pclk, .cmd, .src_irq);
    task chk(input logic [40:0] got, input logic [40:0] want);
        num_checks++;
        miscompares += (got !== want);
        if (got !== want)
            $display("MISMATCH %0t got %h want %h", $time, got, want);
    endtask
    task wrap_up;
        if (miscompares == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Read requests note their expectation before the setup cycle
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [32:0] e);
        int n;
        if (!w)
            q.push_back({e, exp_irq});
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n == 0 || (pready !== 1'b1 && n < 50); n++)
            @(posedge pclk);
        chk(41'(n >= 50), 41'h0);
        if (n >= 50)
            wrap_up;
        else
            {psel, penable} <= 2'b00;
    endtask
    always @(posedge pclk)
        if (psel && penable && pready && !pwrite && q.size() > 0)
            chk(seen, q.pop_front());
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 4; k++)
            apb(1'b0, 8'h18 + 8'(4 * k), 32'h0, 33'h0);
        apb(1'b0, 8'h19, 32'h0, {1'b1, 32'h0});
        // Unmapped index must error and read zero
        apb(1'b0, 8'h28, 32'h0, {1'b1, 32'h0});
        for (int k = 0; k < 96; k++)
        begin
            r = k % 4;
            seed = lfsr(seed);
            sh[r] = seed[15:0] & mk[r];
            if (r == 0)
                cmd <= seed[31:15];
            apb(1'b1, 8'h18 + 8'(4 * r), seed, 33'h0);
            pend = 17'h0;
            exp_irq = 8'h0;
            // Descending scan so a tie keeps the lowest source
            for (int i = 16; i >= 0; i--)
            begin
                c = 2'(sh[ipl_pkg::SRC_REG[i]] >> ipl_pkg::SRC_LSB[i]);
                pend[i] = cmd[i] && c != 2'h0;
                if (pend[i] && c - 2'h1 >= exp_irq[6:5])
                    exp_irq = {1'b1, c - 2'h1, 5'(i)};
            end
            apb(1'b0, 8'h18 + 8'(4 * r), 32'h0, {17'h0, sh[r]});
            apb(1'b0, 8'h40, 32'h0, {16'h0, pend});
            // Winner view shows the raw field code, not the level
            apb(1'b0, 8'h44, 32'h0, {25'h0, exp_irq[7] ?
                {1'b1, exp_irq[6:5] + 2'h1, exp_irq[4:0]} : 8'h0});
        end
        @(posedge pclk);
        wrap_up;
    end
endmodule
bind ipl_regs ipl_regs_monitor mon (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .src_irq, .src_code, .irq_req, .irq_level,
    .irq_src);
